// file: logic/nvmuc_map.svh
`ifndef NVMUC_MAP_SVH
`define NVMUC_MAP_SVH

`define NVMUC_CLK_PERIOD_NS    25
`define NVMUC_NVM_COPY_NS      10000
`define NVMUC_NVM_COPY_CYC     \
  ((`NVMUC_NVM_COPY_NS + `NVMUC_CLK_PERIOD_NS - 1) / `NVMUC_CLK_PERIOD_NS)

`define NVMUC_P0_KEY_ADDR      8'ha2
`define NVMUC_P0_STATUS_ADDR   8'ha3
`define NVMUC_P0_SUBPAGE_ADDR  8'ha4
`define NVMUC_P0_DRVSTAT_ADDR  8'h82
`define NVMUC_P0_CRCRUN_ADDR   8'hef
`define NVMUC_P0_CRC_INC_LO    8'hf0
`define NVMUC_P0_CRC_INC_HI    8'hf1
`define NVMUC_P0_CRC_EXC_LO    8'hf2
`define NVMUC_P0_CRC_EXC_HI    8'hf3
`define NVMUC_P0_CRC_SEQ_LO    8'hfa
`define NVMUC_P0_CRC_SEQ_HI    8'hfb
`define NVMUC_P1_CTRL_ADDR     8'h18
`define NVMUC_P1_SERIAL_ADDR   8'h1a
`define NVMUC_P1_PRIM_ADDR     8'h22
`define NVMUC_P1_SEC_ADDR      8'h23
`define NVMUC_P1_LOCK_ADDR     8'h41
`define NVMUC_P1_BUCK_ADDR     8'h88
`define NVMUC_P1_COPY_ADDR     8'hef
`define NVMUC_P1_COPYSTAT_ADDR 8'hf3

`define NVMUC_BIT_COPY         1
`define NVMUC_BIT_CRCRUN       1
`define NVMUC_BIT_HALT         0
`define NVMUC_BIT_BUCK_UNPROT  3
`define NVMUC_BIT_SPI          0
`define NVMUC_BIT_PRIM_CRC     1
`define NVMUC_BIT_SEC_CRC      2

`define NVMUC_KEY_RESET        8'h00
`define NVMUC_KEY_1            8'h98
`define NVMUC_KEY_2            8'hb8
`define NVMUC_KEY_3            8'h13
`define NVMUC_KEY_4            8'h7d
`define NVMUC_LOCK_OPEN_VAL    8'ha5
`define NVMUC_DRVSTAT_RST      8'h08
`define NVMUC_PRIM_ADDR_RST    8'h48
`define NVMUC_SEC_ADDR_RST     8'h12

`define NVMUC_CRC_POLY         16'h755b
`define NVMUC_CRC_INIT         16'hffff
`define NVMUC_CRC_EXC_MASK     8'h3f
`define NVMUC_CRC_LAST         11'h4ff
`define NVMUC_P4_WDOG_BASE     5'h01

`endif

// file: logic/nvmuc_pkg.sv
package nvmuc_pkg;

  typedef enum logic [2:0]
  {
    UL_IDLE  = 3'b000,
    UL_ARMED = 3'b001,
    UL_KEY1  = 3'b010,
    UL_KEY2  = 3'b011,
    UL_KEY3  = 3'b100,
    UL_OPEN  = 3'b101
  } nvmuc_unlock_e;

  typedef logic [2:0] nvmuc_page_t;

  typedef struct packed
  {
    logic [255:0][7:0]      p0;
    logic [255:0][7:0]      p1;
    logic [2:0][255:0][7:0] p3;
    logic [31:0][7:0]       p4;
    nvmuc_unlock_e          ul;
    logic                   unlocked;
    logic                   locked;
    logic                   nvmBusy;
    logic [15:0]            nvmCnt;
    logic                   crcStart;
    logic                   rspValid;
    logic                   rspAck;
    logic [7:0]             rspData;
  } nvmuc_top_s;

  typedef struct packed
  {
    logic        busy;
    logic        done;
    logic [10:0] cnt;
    logic [15:0] inc;
    logic [15:0] exc;
    logic [15:0] seq;
  } nvmuc_crc_s;

endpackage

// file: logic/nvmuc_crc_engine.sv
`include "nvmuc_map.svh"

module nvmuc_crc_engine
(
  input  wire logic        clk,
  input  wire logic        rstN,
  input  wire logic        start,
  input  wire logic [7:0]  rdData,
  output logic      [2:0]  rdBlock,
  output logic      [7:0]  rdAddr,
  output logic             busy,
  output logic             done,
  output logic      [15:0] crcInc,
  output logic      [15:0] crcExc,
  output logic      [15:0] crcSeq
);
  import nvmuc_pkg::*;

  nvmuc_crc_s st_reg;
  nvmuc_crc_s st_next;

  // Same result as the byte lookup table: MSB first, no reflection
  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic [7:0]  d);
    logic [15:0] r;
    integer      i;
    r = c ^ {d, 8'h00};
    for (i = 0; i < 8; i++)
    begin
      if (r[15])
        r = {r[14:0], 1'b0} ^ `NVMUC_CRC_POLY;
      else
        r = {r[14:0], 1'b0};
    end
    return r;
  endfunction

  always_comb
  begin
    st_next = st_reg;
    st_next.done = 1'b0;
    if (!st_reg.busy)
    begin
      if (start)
      begin
        st_next.busy = 1'b1;
        st_next.cnt  = '0;
        st_next.inc  = `NVMUC_CRC_INIT;
        st_next.exc  = `NVMUC_CRC_INIT;
        st_next.seq  = `NVMUC_CRC_INIT;
      end
    end
    else
    begin
      // Block 0 is the user map, blocks 1 to 4 are pages 1 and 3
      if (st_reg.cnt[10:8] == 3'd0)
      begin
        st_next.inc = crc_step(st_reg.inc, rdData);
        st_next.exc = crc_step(st_reg.exc, rdData & `NVMUC_CRC_EXC_MASK);
      end
      else
        st_next.seq = crc_step(st_reg.seq, rdData);
      if (st_reg.cnt == `NVMUC_CRC_LAST)
      begin
        st_next.busy = 1'b0;
        st_next.done = 1'b1;
      end
      else
        st_next.cnt = st_reg.cnt + 11'h001;
    end
  end

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign rdBlock = st_reg.cnt[10:8];
  assign rdAddr  = st_reg.cnt[7:0];
  assign busy    = st_reg.busy;
  assign done    = st_reg.done;
  assign crcInc  = st_reg.inc;
  assign crcExc  = st_reg.exc;
  assign crcSeq  = st_reg.seq;

endmodule

// file: logic/nvm_update_control.sv
// Notes on behaviour
// - Subpage field 0xA4[1:0] picks which sequencer window page 3 shows.
// - Two-subpage build folds subpage 2 onto 1; host never selects 2.
// - Page 1 0x41 other than 0xA5 locks memory and blocks page 3.
// - Page 1 0xEF bit 1 starts copy when unlocked; 0xF3 bit 1 reads busy.
// - Page 0 0xEF bit 1 runs internal CRC over pages 0,1,3,4.
// - Page 0 0xFB goes from zero to non-zero when CRC finishes.
// - User CRC kept as include 0xF0/F1 and exclude 0xF2/F3, low first.
// - Image 0x11A: bit0 SPI, bit1 primary/SPI CRC, bit2 secondary CRC.
// - Primary target address at 0x122, secondary at 0x123.
// - Page 0 at primary, pages 1/3 at plus 1/3, page 4 at secondary.
// - Serial settings change only when unlocked and act at once.
// - Unlocked: secondary port ignored, page 4 served via primary port.
// - Buck frequency writable only with 0x18 bit 3; set needs unlock.
// - Unlock: 0x00 then 98,B8,13,7D to 0xA2 back to back; sets 0xA3[7:6].
`include "nvmuc_map.svh"

module nvm_update_control
#(
  parameter int SUBPAGES = 3
)
(
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       reqValid,
  input  wire logic       reqWrite,
  input  wire logic       reqSpi,
  input  wire logic       reqSecondary,
  input  wire logic [6:0] reqDevAddr,
  input  wire nvmuc_pkg::nvmuc_page_t reqSpiPage,
  input  wire logic [7:0] reqAddr,
  input  wire logic [7:0] reqWdata,
  output logic            rspValid,
  output logic            rspAck,
  output logic      [7:0] rspData,
  output logic            spiMode,
  output logic            primaryCrcEn,
  output logic            secondaryCrcEn,
  output logic      [6:0] primaryAddr,
  output logic      [6:0] secondaryAddr,
  output logic            sequencerHalt,
  output logic      [7:0] buckFreqSel,
  output logic            unlocked,
  output logic            nvmLocked,
  output logic            nvmBusy,
  output logic            crcBusy
);
  import nvmuc_pkg::*;

  localparam logic [15:0] COPY_CYC = 16'(`NVMUC_NVM_COPY_CYC);

  logic       rstSync1_n;
  logic       rstN;
  nvmuc_top_s st_reg;
  nvmuc_top_s st_next;
  logic [2:0] engBlock;
  logic [7:0] engAddr;
  logic [7:0] engData;
  logic       engBusy;
  logic       engDone;
  logic [15:0] engInc;
  logic [15:0] engExc;
  logic [15:0] engSeq;
  logic [3:0] dec;
  logic [1:0] sub;

  // Returns {hit, page}
  function automatic logic [3:0] decode_target(
    input logic        spi,
    input logic        sec,
    input logic [6:0]  dev,
    input nvmuc_page_t spiPg,
    input logic        spiSel,
    input logic        unl,
    input logic [6:0]  prim,
    input logic [6:0]  secA);
    logic [3:0] r;
    r = 4'h0;
    if (spiSel)
    begin
      if (spi && (spiPg == 3'd0 || spiPg == 3'd1 ||
                  spiPg == 3'd3 || spiPg == 3'd4))
        r = {1'b1, spiPg};
    end
    else if (!spi)
    begin
      if (sec)
      begin
        if (!unl && dev == secA)
          r = 4'hc;
      end
      else if (dev == prim)
        r = 4'h8;
      else if (dev == 7'(prim + 7'h01))
        r = 4'h9;
      else if (dev == 7'(prim + 7'h03))
        r = 4'hb;
      else if (unl && dev == secA)
        r = 4'hc;
    end
    return r;
  endfunction

  // Folds out-of-range selections onto the last existing subpage
  function automatic logic [1:0] clamp_sub(input logic [1:0] s);
    logic [1:0] r;
    r = s;
    if (int'(s) >= SUBPAGES)
      r = 2'(SUBPAGES - 1);
    return r;
  endfunction

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rstSync1_n <= 1'b0;
      rstN       <= 1'b0;
    end
    else
    begin
      rstSync1_n <= 1'b1;
      rstN       <= rstSync1_n;
    end
  end

  // Data path for the internal CRC walk
  always_comb
  begin
    engData = 8'h00;
    case (engBlock)
      3'd0:
      begin
        if (engAddr >= 8'hf0)
          engData = st_reg.p4[5'(engAddr[3:0]) + `NVMUC_P4_WDOG_BASE];
        else
          engData = st_reg.p0[engAddr];
      end
      3'd1:
        engData = st_reg.p1[engAddr];
      3'd2, 3'd3, 3'd4:
        engData = st_reg.p3[clamp_sub(2'(engBlock - 3'd2))][engAddr];
      default:
        engData = 8'h00;
    endcase
  end

  nvmuc_crc_engine u_crc
  (
    .clk     (clk),
    .rstN    (rstN),
    .start   (st_reg.crcStart),
    .rdData  (engData),
    .rdBlock (engBlock),
    .rdAddr  (engAddr),
    .busy    (engBusy),
    .done    (engDone),
    .crcInc  (engInc),
    .crcExc  (engExc),
    .crcSeq  (engSeq)
  );

  assign dec = decode_target(reqSpi, reqSecondary, reqDevAddr, reqSpiPage,
                 st_reg.p1[`NVMUC_P1_SERIAL_ADDR][`NVMUC_BIT_SPI],
                 st_reg.unlocked,
                 st_reg.p1[`NVMUC_P1_PRIM_ADDR][6:0],
                 st_reg.p1[`NVMUC_P1_SEC_ADDR][6:0]);
  assign sub = clamp_sub(st_reg.p0[`NVMUC_P0_SUBPAGE_ADDR][1:0]);

  always_comb
  begin
    logic hit;
    logic isKey;
    hit   = 1'b0;
    isKey = 1'b0;
    st_next          = st_reg;
    st_next.crcStart = 1'b0;
    st_next.rspValid = 1'b0;
    st_next.rspAck   = 1'b0;
    st_next.rspData  = 8'h00;
    st_next.unlocked = (st_reg.ul == UL_OPEN);
    st_next.locked   = st_reg.locked |
      (st_reg.p1[`NVMUC_P1_LOCK_ADDR] != `NVMUC_LOCK_OPEN_VAL);

    if (st_reg.nvmBusy)
    begin
      st_next.nvmCnt = st_reg.nvmCnt - 16'h0001;
      if (st_reg.nvmCnt == 16'h0001)
        st_next.nvmBusy = 1'b0;
    end

    if (reqValid)
    begin
      hit = dec[3] && !(dec[2:0] == 3'd3 && st_reg.locked);
      st_next.rspValid = 1'b1;
      st_next.rspAck   = hit;
      isKey = hit && reqWrite && dec[2:0] == 3'd0 &&
              reqAddr == `NVMUC_P0_KEY_ADDR;
    end

    if (hit && !reqWrite)
    begin
      case (dec[2:0])
        3'd0:
        begin
          st_next.rspData = st_reg.p0[reqAddr];
          if (reqAddr == `NVMUC_P0_KEY_ADDR)
            st_next.rspData = 8'h00;
          else if (reqAddr == `NVMUC_P0_STATUS_ADDR)
            st_next.rspData = {st_reg.unlocked, st_reg.unlocked, 5'h00,
                               st_reg.p0[reqAddr][`NVMUC_BIT_HALT]};
          else if (reqAddr == `NVMUC_P0_CRCRUN_ADDR)
            st_next.rspData = {6'h00, engBusy | st_reg.crcStart, 1'b0};
        end
        3'd1:
        begin
          st_next.rspData = st_reg.p1[reqAddr];
          if (reqAddr == `NVMUC_P1_COPY_ADDR)
            st_next.rspData = 8'h00;
          else if (reqAddr == `NVMUC_P1_COPYSTAT_ADDR)
            st_next.rspData = {6'h00, st_reg.nvmBusy, 1'b0};
        end
        3'd3:
          st_next.rspData = st_reg.p3[sub][reqAddr];
        3'd4:
          st_next.rspData = reqAddr < 8'h20 ? st_reg.p4[reqAddr[4:0]] : 8'h00;
        default:
          st_next.rspData = 8'h00;
      endcase
    end

    if (hit && reqWrite)
    begin
      case (dec[2:0])
        3'd0:
        begin
          case (reqAddr)
            `NVMUC_P0_KEY_ADDR, `NVMUC_P0_DRVSTAT_ADDR:
              st_next.p0[reqAddr] = st_reg.p0[reqAddr];
            `NVMUC_P0_STATUS_ADDR:
              st_next.p0[reqAddr] = {7'h00, reqWdata[`NVMUC_BIT_HALT]};
            `NVMUC_P0_CRCRUN_ADDR:
            begin
              if (reqWdata[`NVMUC_BIT_CRCRUN] && !engBusy)
                st_next.crcStart = 1'b1;
            end
            `NVMUC_P0_SUBPAGE_ADDR:
              st_next.p0[reqAddr] = reqWdata;
            default:
              st_next.p0[reqAddr] = reqWdata;
          endcase
        end
        3'd1:
        begin
          case (reqAddr)
            `NVMUC_P1_SERIAL_ADDR, `NVMUC_P1_PRIM_ADDR,
            `NVMUC_P1_SEC_ADDR:
            begin
              if (st_reg.unlocked)
                st_next.p1[reqAddr] = reqWdata;
            end
            `NVMUC_P1_CTRL_ADDR:
            begin
              st_next.p1[reqAddr] = reqWdata;
              if (!st_reg.unlocked)
                st_next.p1[reqAddr][`NVMUC_BIT_BUCK_UNPROT] =
                  reqWdata[`NVMUC_BIT_BUCK_UNPROT] &
                  st_reg.p1[reqAddr][`NVMUC_BIT_BUCK_UNPROT];
            end
            `NVMUC_P1_BUCK_ADDR:
            begin
              if (st_reg.p1[`NVMUC_P1_CTRL_ADDR][`NVMUC_BIT_BUCK_UNPROT])
                st_next.p1[reqAddr] = reqWdata;
            end
            `NVMUC_P1_COPY_ADDR:
            begin
              if (reqWdata[`NVMUC_BIT_COPY] && st_reg.unlocked &&
                  !st_reg.locked && !st_reg.nvmBusy)
              begin
                st_next.nvmBusy = 1'b1;
                st_next.nvmCnt  = COPY_CYC;
              end
            end
            `NVMUC_P1_COPYSTAT_ADDR:
              st_next.p1[reqAddr] = st_reg.p1[reqAddr];
            default:
              st_next.p1[reqAddr] = reqWdata;
          endcase
        end
        3'd3:
          st_next.p3[sub][reqAddr] = reqWdata;
        3'd4:
        begin
          if (reqAddr < 8'h20)
            st_next.p4[reqAddr[4:0]] = reqWdata;
        end
        default:
          st_next.p0[reqAddr] = st_reg.p0[reqAddr];
      endcase
    end

    // Key sequence; any other acknowledged access in between aborts it
    if (hit)
    begin
      if (isKey && reqWdata == `NVMUC_KEY_RESET)
        st_next.ul = UL_ARMED;
      else
      begin
        case (st_reg.ul)
          UL_ARMED:
            st_next.ul = (isKey && reqWdata == `NVMUC_KEY_1) ?
                         UL_KEY1 : UL_IDLE;
          UL_KEY1:
            st_next.ul = (isKey && reqWdata == `NVMUC_KEY_2) ?
                         UL_KEY2 : UL_IDLE;
          UL_KEY2:
            st_next.ul = (isKey && reqWdata == `NVMUC_KEY_3) ?
                         UL_KEY3 : UL_IDLE;
          UL_KEY3:
            st_next.ul = (isKey && reqWdata == `NVMUC_KEY_4 &&
                          !st_reg.locked) ? UL_OPEN : UL_IDLE;
          UL_OPEN:
            st_next.ul = UL_OPEN;
          UL_IDLE:
            st_next.ul = UL_IDLE;
          default:
            st_next.ul = UL_IDLE;
        endcase
      end
    end

    // Engine results override a host write in the same cycle
    if (engDone)
    begin
      st_next.p0[`NVMUC_P0_CRC_INC_LO] = engInc[7:0];
      st_next.p0[`NVMUC_P0_CRC_INC_HI] = engInc[15:8];
      st_next.p0[`NVMUC_P0_CRC_EXC_LO] = engExc[7:0];
      st_next.p0[`NVMUC_P0_CRC_EXC_HI] = engExc[15:8];
      st_next.p0[`NVMUC_P0_CRC_SEQ_LO] = engSeq[7:0];
      st_next.p0[`NVMUC_P0_CRC_SEQ_HI] =
        (engSeq[15:8] == 8'h00) ? 8'h01 : engSeq[15:8];
    end
  end

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      st_reg <= '0;
      st_reg.p0[`NVMUC_P0_DRVSTAT_ADDR] <= `NVMUC_DRVSTAT_RST;
      st_reg.p1[`NVMUC_P1_LOCK_ADDR]    <= `NVMUC_LOCK_OPEN_VAL;
      st_reg.p1[`NVMUC_P1_PRIM_ADDR]    <= `NVMUC_PRIM_ADDR_RST;
      st_reg.p1[`NVMUC_P1_SEC_ADDR]     <= `NVMUC_SEC_ADDR_RST;
      st_reg.ul <= UL_IDLE;
    end
    else
      st_reg <= st_next;
  end

  assign rspValid       = st_reg.rspValid;
  assign rspAck         = st_reg.rspAck;
  assign rspData        = st_reg.rspData;
  assign spiMode        = st_reg.p1[`NVMUC_P1_SERIAL_ADDR][`NVMUC_BIT_SPI];
  assign primaryCrcEn   =
    st_reg.p1[`NVMUC_P1_SERIAL_ADDR][`NVMUC_BIT_PRIM_CRC];
  assign secondaryCrcEn =
    st_reg.p1[`NVMUC_P1_SERIAL_ADDR][`NVMUC_BIT_SEC_CRC];
  assign primaryAddr    = st_reg.p1[`NVMUC_P1_PRIM_ADDR][6:0];
  assign secondaryAddr  = st_reg.p1[`NVMUC_P1_SEC_ADDR][6:0];
  assign sequencerHalt  = st_reg.p0[`NVMUC_P0_STATUS_ADDR][`NVMUC_BIT_HALT];
  assign buckFreqSel    = st_reg.p1[`NVMUC_P1_BUCK_ADDR];
  assign unlocked       = st_reg.unlocked;
  assign nvmLocked      = st_reg.locked;
  assign nvmBusy        = st_reg.nvmBusy;
  assign crcBusy        = engBusy;

endmodule

// file: bench/nvmuc_host.sv
module nvmuc_host
(
  input  wire logic              clk,
  input  wire logic              rspAck,
  input  wire logic        [7:0] rspData,
  output logic                   reqValid,
  output logic                   reqWrite,
  output logic                   reqSpi,
  output logic                   reqSecondary,
  output logic             [6:0] reqDevAddr,
  output nvmuc_pkg::nvmuc_page_t reqSpiPage,
  output logic             [7:0] reqAddr,
  output logic             [7:0] reqWdata
);
  timeunit 1ns;
  timeprecision 100ps;
  import nvmuc_pkg::*;

  localparam logic [7:0] KEYS [5] = '{8'h00, 8'h98, 8'hb8, 8'h13, 8'h7d};

  initial
    {reqValid, reqWrite, reqSpi, reqSecondary, reqDevAddr, reqSpiPage,
     reqAddr, reqWdata} = '0;

  // Port 0 primary, 1 secondary, 2 serial-peripheral with page in dev
  task automatic xfer(input logic [1:0] port, input logic w,
                      input logic [6:0] dev, input logic [7:0] a, d,
                      output logic ack, output logic [7:0] q);
    @(posedge clk);
    reqValid <= 1'b1;
    reqWrite <= w;
    reqSpi <= (port == 2'h2);
    reqSecondary <= (port == 2'h1);
    reqDevAddr <= dev;
    reqSpiPage <= dev[2:0];
    reqAddr <= a;
    reqWdata <= d;
    @(posedge clk);
    reqValid <= 1'b0;
    reqAddr <= ~a;
    reqWdata <= ~d;
    #1;
    ack = rspAck;
    q = rspData;
  endtask

  // Key sequence with nothing in between, then halt keeping open bits
  task automatic unlock(input logic [6:0] p0);
    logic       ack;
    logic [7:0] q;
    for (int i = 0; i < 5; i++)
      xfer(2'h0, 1'b1, p0, 8'ha2, KEYS[i], ack, q);
    xfer(2'h0, 1'b1, p0, 8'ha3, 8'hc1, ack, q);
  endtask
endmodule

// file: bench/nvm_update_control_sva.sv
module nvmuc_checker
(
  input wire logic       clk,
  input wire logic       arst_n,
  input wire logic       reqValid,
  input wire logic       reqWrite,
  input wire logic       reqSpi,
  input wire logic       reqSecondary,
  input wire logic [7:0] reqAddr,
  input wire logic [7:0] reqWdata,
  input wire logic       rspValid,
  input wire logic       rspAck,
  input wire logic       spiMode,
  input wire logic       primaryCrcEn,
  input wire logic       secondaryCrcEn,
  input wire logic [6:0] primaryAddr,
  input wire logic [6:0] secondaryAddr,
  input wire logic       unlocked,
  input wire logic       nvmLocked,
  input wire logic       nvmBusy,
  input wire logic       crcBusy
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [10:0] copyCnt_reg;
  logic [10:0] crcCnt_reg;

  // Length of the current busy run, read on its falling edge
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      copyCnt_reg <= 11'h0;
      crcCnt_reg <= 11'h0;
    end
    else
    begin
      copyCnt_reg <= nvmBusy ? copyCnt_reg + 11'h1 : 11'h0;
      crcCnt_reg <= crcBusy ? crcCnt_reg + 11'h1 : 11'h0;
    end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  a_rsp_follows:
    assert property (reqValid |=> rspValid)
    else $error("response missing");
  a_copy_start:
    assert property ($rose(nvmBusy) |-> $past(reqValid && reqWrite &&
      reqAddr == 8'hef && reqWdata[1] && unlocked && !nvmLocked))
    else $error("copy started without cause");
  a_copy_len:
    assert property ($fell(nvmBusy) |-> copyCnt_reg == 11'h190)
    else $error("copy length wrong");
  a_lock_sticky:
    assert property (nvmLocked |=> nvmLocked)
    else $error("lock flag dropped");
  a_lock_cause:
    assert property ($rose(nvmLocked) |-> $past(reqValid && reqWrite &&
      reqAddr == 8'h41 && reqWdata != 8'ha5, 2))
    else $error("lock without cause");
  a_unlock_key:
    assert property ($rose(unlocked) |-> $past(reqValid && reqWrite &&
      reqAddr == 8'ha2 && reqWdata == 8'h7d, 2))
    else $error("unlock without final key");
  a_serial_frozen:
    assert property (!unlocked ##1 !unlocked |-> $stable({spiMode,
      primaryCrcEn, secondaryCrcEn, primaryAddr, secondaryAddr}))
    else $error("serial setting changed while closed");
  a_sec_ignored:
    assert property (reqValid && reqSecondary && !reqSpi && unlocked
      |=> !rspAck)
    else $error("secondary port served while open");
  a_crc_start:
    assert property ($rose(crcBusy) |-> $past(reqValid && reqWrite &&
      reqAddr == 8'hef && reqWdata[1], 2))
    else $error("crc started without cause");
  a_crc_len:
    assert property ($fell(crcBusy) |-> crcCnt_reg == 11'h500)
    else $error("crc length wrong");
endmodule

bind nvm_update_control nvmuc_checker i_chk (.clk, .arst_n, .reqValid,
  .reqWrite, .reqSpi, .reqSecondary, .reqAddr, .reqWdata, .rspValid,
  .rspAck, .spiMode, .primaryCrcEn, .secondaryCrcEn, .primaryAddr,
  .secondaryAddr, .unlocked, .nvmLocked, .nvmBusy, .crcBusy);

// file: bench/nvm_update_control_tb.sv
module nvm_update_control_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import nvmuc_pkg::*;

  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        reqValid, reqWrite, reqSpi, reqSecondary, rspValid;
  logic        rspAck, spiMode, primaryCrcEn, secondaryCrcEn, ack;
  logic        sequencerHalt, unlocked, nvmLocked, nvmBusy, crcBusy;
  logic  [6:0] reqDevAddr, primaryAddr, secondaryAddr;
  logic  [7:0] reqAddr, reqWdata, rspData, buckFreqSel, q, b, v;
  logic  [7:0] sp [3];
  logic  [7:0] img [256];
  logic [15:0] crcExp;
  nvmuc_page_t reqSpiPage;
  int          num_errors = 0;
  int          n_compared = 0;
  int          n;

  always #12.5 clk = ~clk;

  nvm_update_control #(.SUBPAGES(3)) i_dut (.clk, .arst_n, .reqValid,
    .reqWrite, .reqSpi, .reqSecondary, .reqDevAddr, .reqSpiPage, .reqAddr,
    .reqWdata, .rspValid, .rspAck, .rspData, .spiMode, .primaryCrcEn,
    .secondaryCrcEn, .primaryAddr, .secondaryAddr, .sequencerHalt,
    .buckFreqSel, .unlocked, .nvmLocked, .nvmBusy, .crcBusy);

  nvmuc_host i_host (.clk, .rspAck, .rspData, .reqValid, .reqWrite,
    .reqSpi, .reqSecondary, .reqDevAddr, .reqSpiPage, .reqAddr, .reqWdata);

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [8:0] got, exp, input string m);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask

  // Host-side CRC: seed, then one table lookup per masked byte
  function automatic logic [15:0] host_crc(input logic [7:0] im [256],
                                           input logic [7:0] msk);
    logic [15:0] tbl [256];
    logic [15:0] c;
    tbl[0] = 16'h0000;
    c = 16'h8000;
    for (int i = 1; i < 256; i <<= 1)
    begin
      c = c[15] ? ({c[14:0], 1'b0} ^ 16'h755b) : {c[14:0], 1'b0};
      for (int j = 0; j < i; j++)
        tbl[i + j] = c ^ tbl[j];
    end
    c = 16'hffff;
    for (int a = 0; a < 256; a++)
      c = {c[7:0], 8'h00} ^ tbl[(im[a] & msk) ^ c[15:8]];
    return c;
  endfunction

  task automatic wr(input logic [6:0] dev, input logic [7:0] a, d);
    i_host.xfer(2'h0, 1'b1, dev, a, d, ack, q);
  endtask

  // Expected value carries the acknowledge in bit 8
  task automatic rd(input logic [1:0] p, input logic [6:0] dev,
                    input logic [7:0] a, input logic [8:0] e, string m);
    i_host.xfer(p, 1'b0, dev, a, 8'h00, ack, q);
    chk({ack, q}, e, m);
  endtask

  // Read until the masked value equals v (inv 0) or leaves v (inv 1)
  task automatic poll(input logic [6:0] dev, input logic [7:0] a, m, v,
                      input logic inv);
    n = 0;
    do
    begin
      i_host.xfer(2'h0, 1'b0, dev, a, 8'h00, ack, q);
      n++;
    end
    while ((((q & m) == v) === inv) && n < 1000);
    if (((q & m) == v) === inv)
    begin
      chk(9'h0, 9'h1, "poll limit");
      close_out();
    end
  endtask

  initial
  begin
    void'($urandom(42326));
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk({2'h0, primaryAddr}, 9'h048, "prim addr");
    chk({2'h0, secondaryAddr}, 9'h012, "sec addr");
    rd(2'h0, 7'h49, 8'h41, 9'h1a5, "lock reg");
    rd(2'h0, 7'h48, 8'h82, 9'h108, "drive status");
    wr(7'h49, 8'h1a, 8'h01);
    wr(7'h49, 8'hef, 8'h02);
    wr(7'h49, 8'h18, 8'h08);
    chk(9'({spiMode, nvmBusy, sequencerHalt}), 9'h0, "closed");
    rd(2'h0, 7'h49, 8'h18, 9'h100, "protect bit");
    $display("test closed done");
    i_host.unlock(7'h48);
    rd(2'h0, 7'h48, 8'ha3, 9'h1c1, "unlock status");
    chk(9'({unlocked, sequencerHalt}), 9'h3, "open halt");
    rd(2'h1, 7'h12, 8'h05, 9'h000, "sec port");
    v = 8'($urandom);
    wr(7'h12, 8'h05, v);
    rd(2'h0, 7'h12, 8'h05, {1'b1, v}, "page4 primary");
    $display("test unlock done");
    // Sequencer program goes in after pages 0, 1 and 4
    for (int s = 0; s < 3; s++)
    begin
      sp[s] = {6'($urandom), 2'(s)};
      wr(7'h48, 8'ha4, 8'(s));
      wr(7'h4b, 8'h10, sp[s]);
    end
    wr(7'h48, 8'ha4, 8'h03);
    rd(2'h0, 7'h4b, 8'h10, {1'b1, sp[2]}, "subpage fold");
    for (int s = 2; s >= 0; s--)
    begin
      wr(7'h48, 8'ha4, 8'(s));
      rd(2'h0, 7'h48, 8'ha4, {1'b1, 8'(s)}, "subpage sel");
      rd(2'h0, 7'h4b, 8'h10, {1'b1, sp[s]}, "subpage");
    end
    $display("test subpage done");
    b = 8'($urandom);
    wr(7'h49, 8'h88, ~b);
    chk({1'b0, buckFreqSel}, 9'h0, "buck guarded");
    wr(7'h49, 8'h18, 8'h48);
    wr(7'h49, 8'h88, b);
    chk({1'b0, buckFreqSel}, {1'b0, b}, "buck set");
    wr(7'h49, 8'h18, 8'h40);
    wr(7'h49, 8'h88, ~b);
    chk({1'b0, buckFreqSel}, {1'b0, b}, "buck reguarded");
    $display("test buck done");
    wr(7'h49, 8'h1a, 8'h06);
    chk(9'({spiMode, primaryCrcEn, secondaryCrcEn}), 9'h3, "crc en");
    wr(7'h49, 8'h22, 8'h28);
    chk({2'h0, primaryAddr}, 9'h028, "new addr");
    rd(2'h0, 7'h49, 8'h1a, 9'h000, "old addr");
    rd(2'h0, 7'h29, 8'h1a, 9'h106, "page1 moved");
    wr(7'h29, 8'h1a, 8'h07);
    repeat (8) @(posedge clk);
    rd(2'h0, 7'h29, 8'h1a, 9'h000, "i2c in spi mode");
    rd(2'h2, 7'h01, 8'h1a, 9'h107, "spi page1");
    i_host.xfer(2'h2, 1'b1, 7'h01, 8'h1a, 8'h00, ack, q);
    repeat (8) @(posedge clk);
    rd(2'h0, 7'h2b, 8'h10, {1'b1, sp[0]}, "page3 moved");
    $display("test serial done");
    for (int a = 8'hf0; a <= 8'hfb; a++)
      wr(7'h28, 8'(a), 8'h00);
    rd(2'h0, 7'h29, 8'h18, 9'h140, "crc enabled");
    wr(7'h28, 8'hef, 8'h02);
    rd(2'h0, 7'h28, 8'hfb, 9'h100, "crc cleared");
    poll(7'h28, 8'hfb, 8'hff, 8'h00, 1'b1);
    // Image as written so far; top positions take page 4 from 0x01
    img = '{default: 8'h00};
    img[8'h82] = 8'h08;
    img[8'ha3] = 8'h01;
    img[8'hf4] = v;
    crcExp = host_crc(img, 8'hff);
    rd(2'h0, 7'h28, 8'hf0, {1'b1, crcExp[7:0]}, "crc inc lo");
    rd(2'h0, 7'h28, 8'hf1, {1'b1, crcExp[15:8]}, "crc inc hi");
    // Exclude mask is the block's own choice
    crcExp = host_crc(img, 8'h3f);
    rd(2'h0, 7'h28, 8'hf2, {1'b1, crcExp[7:0]}, "crc exc lo");
    rd(2'h0, 7'h28, 8'hf3, {1'b1, crcExp[15:8]}, "crc exc hi");
    rd(2'h0, 7'h28, 8'hef, 9'h100, "crc self clear");
    $display("test crc done");
    wr(7'h29, 8'hef, 8'h02);
    rd(2'h0, 7'h29, 8'hf3, 9'h102, "copy busy");
    poll(7'h29, 8'hf3, 8'h02, 8'h00, 1'b0);
    chk(9'(n >= 199 && n <= 202), 9'h1, "copy time");
    $display("test copy done");
    wr(7'h29, 8'h41, 8'h00);
    wr(7'h29, 8'h41, 8'ha5);
    chk(9'(nvmLocked), 9'h1, "lock");
    rd(2'h0, 7'h2b, 8'h10, 9'h000, "page3 locked");
    rd(2'h0, 7'h28, 8'ha4, 9'h100, "map open");
    wr(7'h29, 8'hef, 8'h02);
    chk(9'(nvmBusy), 9'h0, "copy locked");
    $display("test lock done");
    close_out();
  end
endmodule
